// [acg_glue.sv]
// Purpose: Channel decode, conversion clock routing and trigger glue
//          around a 10-bit successive-approximation converter core.
// Assumes: Classic Wishbone slave, 32-bit data, zero-wait single ack.
// Notes:   Clock sources reach the core as enables on i_ref_clk.
// Function
// - 5-bit channel select; nine inputs exist: 0-3, 8-11 and 27
// - Unimplemented codes 4-7 and 12-21 connect the converter to low reference; 22-25 and 28 are reserved
// - Each pin channel 0-3, 8-11 has its own pin control bit
// - Code 11010 temperature, 11101 high ref, 11110 low ref
// - Clock source: bus, bus halved, async clock, alternate input
// - Alternate input is external reference, live only in external modes
// - Alternate clock passes through the programmable divider
// - Alternate clock keeps running in wait when external conditions hold
// - Alternate clock unusable as conversion clock in stop3
// - Hardware trigger on: one conversion per periodic counter overflow
// - Counter clocked by external reference or 1 kHz internal source
// - Counter runs freely, overflow rate from rate select and clock
// - Only two analog pin enable registers exist
// - The deepest stop1 mode is not provided
// - Control write aborts when busy, and restarts unless channel is all ones
//
// Register access over Wishbone and the register addresses are this design's own decisions.
`include "acg_cfg.svh"
`default_nettype none
module acg_glue
(
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst_b,
   // Wishbone slave
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [7:0]  i_wb_adr,
   input  wire logic [3:0]  i_wb_sel,
   input  wire logic [31:0] i_wb_dat,
   output logic [31:0]      o_wb_dat,
   output logic             o_wb_ack,
   // Clock and mode inputs
   input  wire logic        i_ext_ref_tick,
   input  wire logic        i_async_tick,
   input  wire logic        i_ext_clk_mode,
   input  wire logic        i_clock_select_bit_1,
   input  wire logic        i_wait_mode,
   input  wire logic        i_stop3_mode,
   input  wire logic        i_core_done,
   // Converter core and mux
   output logic [4:0]       o_channel_select,
   output logic [2:0]       o_input_kind,
   output logic [15:0]      o_pin_enable,
   output logic             o_conv_start,
   output logic             o_conv_abort,
   output logic             o_conv_clk_en,
   output logic             o_module_off,
   output logic             o_bandgap_buffer_enable,
   output logic             o_lvd_enable,
   output logic             o_lvd_stop_enable
);
   logic [1:0]  rst_sync;
   logic        rst_n;
   logic [4:0]  channel_select;
   logic        hw_trig_en;
   logic [1:0]  clk_src;
   logic [1:0]  clk_div;
   logic [7:0]  pin_en_1;
   logic [7:0]  pin_en_2;
   logic [2:0]  pwr;
   logic [2:0]  rate_sel;
   logic        half_tog;
   logic [17:0] lf_cnt;
   logic        lf_tick;
   logic        busy;
   logic        ovf;
   logic        alt_live;
   logic        src_en;
   logic        conv_en;
   logic        ack_pend;
   acg_pkg::acg_st_e st;
   acg_pkg::acg_st_e next_st;

   // Reset release through two flops
   always_ff @(posedge i_ref_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         rst_sync <= 2'b00;
      else
         rst_sync <= {rst_sync[0], 1'b1};
   end
   assign rst_n = rst_sync[1];

   // Input kind per channel code
   function automatic acg_pkg::acg_in_e kind_of(input logic [4:0] ch);
      acg_pkg::acg_in_e k;
      k = acg_pkg::ACG_IN_VRL;
      if (ch[4:3] == 2'b00 || ch[4:3] == 2'b01)
         k = (ch[2] == 1'b0) ? acg_pkg::ACG_IN_PIN
                             : acg_pkg::ACG_IN_VRL;
      else if (ch == `ACG_CH_TEMP)
         k = acg_pkg::ACG_IN_TEMP;
      else if (ch == `ACG_CH_BANDGAP)
         k = acg_pkg::ACG_IN_BG;
      else if (ch == `ACG_CH_VREFH)
         k = acg_pkg::ACG_IN_VRH;
      else if (ch == `ACG_CH_VREFL)
         k = acg_pkg::ACG_IN_VRL;
      else if (ch == `ACG_CH_OFF)
         k = acg_pkg::ACG_IN_OFF;
      else if (ch >= 5'h16)
         k = acg_pkg::ACG_IN_RSV;
      return k;
   endfunction

   // Bus decode
   wire wb_req   = i_wb_cyc && i_wb_stb && !o_wb_ack;
   wire wb_wr    = wb_req && i_wb_we && i_wb_sel[0];
   wire wr_ctrl  = wb_wr && (i_wb_adr == `ACG_OFS_CTRL);
   wire wr_clk   = wb_wr && (i_wb_adr == `ACG_OFS_CLK);
   wire wr_pin1  = wb_wr && (i_wb_adr == `ACG_OFS_PIN1);
   wire wr_pin2  = wb_wr && (i_wb_adr == `ACG_OFS_PIN2);
   wire wr_pwr   = wb_wr && (i_wb_adr == `ACG_OFS_PWR);
   wire wr_per   = wb_wr && (i_wb_adr == `ACG_OFS_PER);
   wire [4:0] wr_ch = i_wb_dat[`ACG_CTRL_CH_LSB +: 5];

   // Write effects
   always_ff @(posedge i_ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         {hw_trig_en, channel_select} <= `ACG_CTRL_RST;
         {clk_div, clk_src}           <= `ACG_CLK_RST;
         pin_en_1       <= 8'h00;
         pin_en_2       <= 8'h00;
         pwr            <= `ACG_PWR_RST;
         rate_sel       <= `ACG_PER_RST;
      end
      else
      begin
         if (wr_ctrl)
         begin
            channel_select <= wr_ch;
            hw_trig_en     <= i_wb_dat[`ACG_CTRL_HWT_BIT];
         end
         if (wr_clk)
         begin
            clk_src <= i_wb_dat[`ACG_CLK_SRC_LSB +: 2];
            clk_div <= i_wb_dat[`ACG_CLK_DIV_LSB +: 2];
         end
         if (wr_pin1)
            pin_en_1 <= i_wb_dat[7:0];
         if (wr_pin2)
            pin_en_2 <= i_wb_dat[7:0];
         if (wr_pwr)
            pwr <= i_wb_dat[2:0];
         if (wr_per)
            rate_sel <= i_wb_dat[2:0];
      end
   end

   // Readback; unmapped addresses read zero and still ack
   wire [31:0] rd_mux =
      (i_wb_adr == `ACG_OFS_CTRL) ?
         {26'h000_0000, hw_trig_en, channel_select} :
      (i_wb_adr == `ACG_OFS_CLK)  ? {28'h000_0000, clk_div, clk_src} :
      (i_wb_adr == `ACG_OFS_PIN1) ? {24'h00_0000, pin_en_1} :
      (i_wb_adr == `ACG_OFS_PIN2) ? {24'h00_0000, pin_en_2} :
      (i_wb_adr == `ACG_OFS_PWR)  ? {29'h0000_0000, pwr} :
      (i_wb_adr == `ACG_OFS_PER)  ? {29'h0000_0000, rate_sel} :
      (i_wb_adr == `ACG_OFS_STAT) ?
         {29'h0000_0000, alt_live, busy, o_module_off} :
      32'h0000_0000;

   always_ff @(posedge i_ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h0000_0000;
      end
      else
      begin
         o_wb_ack <= wb_req;
         o_wb_dat <= wb_req ? rd_mux : 32'h0000_0000;
      end
   end
   assign ack_pend = o_wb_ack;

   // 1 kHz internal tick for the periodic counter
   wire lf_wrap = (lf_cnt == 18'(`ACG_LF_CYCLES - 1));
   always_ff @(posedge i_ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lf_cnt   <= 18'h0_0000;
         lf_tick  <= 1'b0;
         half_tog <= 1'b0;
      end
      else
      begin
         lf_cnt   <= lf_wrap ? 18'h0_0000 : lf_cnt + 18'h0_0001;
         lf_tick  <= lf_wrap;
         half_tog <= ~half_tog;
      end
   end

   // External reference only lives in external modes, not in stop3;
   // stop1 does not exist so no further gating applies
   assign alt_live = i_ext_clk_mode && i_clock_select_bit_1
                     && !i_stop3_mode;
   // Wait mode does not gate the alternate clock
   wire alt_tick = i_ext_ref_tick && alt_live;
   // Counter source: external ref when live, else internal 1 kHz
   wire per_tick = alt_live ? i_ext_ref_tick : lf_tick;

   acg_per_cnt u_per
   (
      .i_ref_clk  (i_ref_clk),
      .i_rst_n    (rst_n),
      .i_tick     (per_tick),
      .i_rate_sel (rate_sel),
      .o_ovf      (ovf)
   );

   // Conversion clock source select; alternate blocked in stop3
   always_comb
   begin
      case (acg_pkg::acg_src_e'(clk_src))
         acg_pkg::ACG_SRC_BUS:  src_en = 1'b1;
         acg_pkg::ACG_SRC_HALF: src_en = half_tog;
         acg_pkg::ACG_SRC_ALT:  src_en = alt_tick;
         acg_pkg::ACG_SRC_ASYN: src_en = i_async_tick;
         default:               src_en = 1'b0;
      endcase
   end

   acg_clk_div u_div
   (
      .i_ref_clk (i_ref_clk),
      .i_rst_n   (rst_n),
      .i_src_en  (src_en),
      .i_div     (clk_div),
      .o_conv_en (conv_en)
   );

   // Start sources
   wire module_off = (channel_select == `ACG_CH_OFF);
   wire sw_start   = wr_ctrl && (wr_ch != `ACG_CH_OFF);
   wire hw_start   = hw_trig_en && ovf && !module_off;
   // Overflows count only with the trigger enabled
   wire any_start  = sw_start || hw_start;

   always_comb
   begin
      case (st)
         acg_pkg::ACG_ST_IDLE:
            next_st = any_start ? acg_pkg::ACG_ST_START : acg_pkg::ACG_ST_IDLE;
         acg_pkg::ACG_ST_START:
            next_st = acg_pkg::ACG_ST_BUSY;
         acg_pkg::ACG_ST_BUSY:
            next_st = any_start ? acg_pkg::ACG_ST_START :
                      (i_core_done || wr_ctrl) ? acg_pkg::ACG_ST_IDLE :
                      acg_pkg::ACG_ST_BUSY;
         default:
            next_st = acg_pkg::ACG_ST_IDLE;
      endcase
   end
   assign busy = (st != acg_pkg::ACG_ST_IDLE);

   always_ff @(posedge i_ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         st <= acg_pkg::ACG_ST_IDLE;
      else
         st <= next_st;
   end

   // Pin bits 0-3 and 8-11 only; others stay zero
   wire [15:0] pin_map = {4'h0, pin_en_2[3:0], 4'h0, pin_en_1[3:0]};
   // Registered outputs to core
   always_ff @(posedge i_ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         o_channel_select        <= `ACG_CH_OFF;
         o_input_kind            <= acg_pkg::ACG_IN_OFF;
         o_pin_enable            <= 16'h0000;
         o_conv_start            <= 1'b0;
         o_conv_abort            <= 1'b0;
         o_conv_clk_en           <= 1'b0;
         o_module_off            <= 1'b1;
         o_bandgap_buffer_enable <= 1'b0;
         o_lvd_enable            <= 1'b0;
         o_lvd_stop_enable       <= 1'b0;
      end
      else
      begin
         o_channel_select <= channel_select;
         o_input_kind     <= kind_of(channel_select);
         o_pin_enable     <= pin_map;
         o_conv_start     <= any_start;
         o_conv_abort     <= wr_ctrl && busy;
         o_conv_clk_en    <= conv_en && !module_off;
         o_module_off     <= module_off;
         // Software must enable these itself before bandgap or stop3 use
         o_bandgap_buffer_enable <= pwr[`ACG_PWR_BANDGAP_BUFFER_ENABLE_BIT];
         o_lvd_enable      <= pwr[`ACG_PWR_LOW_VOLTAGE_DETECT_ENABLE_BIT];
         o_lvd_stop_enable <= pwr[`ACG_PWR_LOW_VOLTAGE_DETECT_STOP_ENABLE_BIT];
      end
   end

   // Assertions
   property p_sw_start;
      @(posedge i_ref_clk) disable iff (!rst_n)
      (wr_ctrl && wr_ch != `ACG_CH_OFF) |=> o_conv_start;
   endproperty
   a_sw_start: assert property (p_sw_start)
      else $error("Control write did not start a conversion");

   property p_off_no_start;
      @(posedge i_ref_clk) disable iff (!rst_n)
      (wr_ctrl && wr_ch == `ACG_CH_OFF && !ovf) |=> !o_conv_start;
   endproperty
   a_off_no_start: assert property (p_off_no_start)
      else $error("All-ones channel started a conversion");

   property p_hw_ignored;
      @(posedge i_ref_clk) disable iff (!rst_n)
      (ovf && !hw_trig_en && !wr_ctrl) |=> !o_conv_start;
   endproperty
   a_hw_ignored: assert property (p_hw_ignored)
      else $error("Overflow started conversion with trigger off");

   property p_hw_start;
      @(posedge i_ref_clk) disable iff (!rst_n)
      (ovf && hw_trig_en && !module_off) |=> o_conv_start;
   endproperty
   a_hw_start: assert property (p_hw_start)
      else $error("Overflow missed with trigger on");

   property p_unimpl_vrl;
      @(posedge i_ref_clk) disable iff (!rst_n)
      (channel_select[4:2] == 3'b001)
         |=> (o_input_kind == acg_pkg::ACG_IN_VRL);
   endproperty
   a_unimpl_vrl: assert property (p_unimpl_vrl)
      else $error("Unimplemented channel not on low reference");

   property p_vrefh;
      @(posedge i_ref_clk) disable iff (!rst_n)
      (channel_select == `ACG_CH_VREFH)
         |=> (o_input_kind == acg_pkg::ACG_IN_VRH);
   endproperty
   a_vrefh: assert property (p_vrefh)
      else $error("High reference code misdecoded");

   property p_alt_stop3;
      @(posedge i_ref_clk) disable iff (!rst_n)
      (clk_src == 2'h2 && i_stop3_mode) |-> !src_en;
   endproperty
   a_alt_stop3: assert property (p_alt_stop3)
      else $error("Alternate clock used in stop3");

   property p_pin_bits;
      @(posedge i_ref_clk) disable iff (!rst_n)
      ##1 (o_pin_enable[15:12] == 4'h0 && o_pin_enable[7:4] == 4'h0);
   endproperty
   a_pin_bits: assert property (p_pin_bits)
      else $error("Pin enable set for non-pin channel");

   property p_ack_once;
      @(posedge i_ref_clk) disable iff (!rst_n)
      ack_pend |=> !o_wb_ack;
   endproperty
   a_ack_once: assert property (p_ack_once)
      else $error("Ack held two cycles");
endmodule // acg_glue
`default_nettype wire

// [acg_cfg.svh]
// Purpose: Offsets, field positions, reset values and counts for the
//          converter glue block.
// Assumes: 32-bit classic Wishbone, word-aligned registers.
// Notes:   Definitions only.
`ifndef ACG_CFG_SVH
`define ACG_CFG_SVH

// Register byte addresses
`define ACG_OFS_CTRL      8'h00
`define ACG_OFS_CLK       8'h04
`define ACG_OFS_PIN1      8'h08
`define ACG_OFS_PIN2      8'h0C
`define ACG_OFS_PWR       8'h10
`define ACG_OFS_PER       8'h14
`define ACG_OFS_STAT      8'h18

// Control register fields
`define ACG_CTRL_CH_LSB   0
`define ACG_CTRL_HWT_BIT  5
`define ACG_CTRL_RST      6'h1F
// Clock register fields
`define ACG_CLK_SRC_LSB   0
`define ACG_CLK_DIV_LSB   2
`define ACG_CLK_RST       4'h0
// Power register fields
`define ACG_PWR_BANDGAP_BUFFER_ENABLE_BIT  0
`define ACG_PWR_LOW_VOLTAGE_DETECT_ENABLE_BIT  1
`define ACG_PWR_LOW_VOLTAGE_DETECT_STOP_ENABLE_BIT 2
`define ACG_PWR_RST       3'h0
// Periodic counter rate select reset
`define ACG_PER_RST       3'h0

// Channel codes
`define ACG_CH_TEMP       5'h1A
`define ACG_CH_BANDGAP    5'h1B
`define ACG_CH_VREFH      5'h1D
`define ACG_CH_VREFL      5'h1E
`define ACG_CH_OFF        5'h1F

// Low-frequency tick: 1 kHz nominal from a 200 MHz clock
`define ACG_CLK_HZ        200000000
`define ACG_LF_HZ         1000
`define ACG_LF_CYCLES     (`ACG_CLK_HZ / `ACG_LF_HZ)

`endif

// [acg_pkg.sv]
// Purpose: Types shared by the converter glue block.
// Assumes: Nothing beyond the config header.
// Notes:   Codes for the clock mux and analog input kind.
`default_nettype none
package acg_pkg;
   typedef enum logic [1:0] {
      ACG_SRC_BUS  = 2'h0,
      ACG_SRC_HALF = 2'h1,
      ACG_SRC_ALT  = 2'h2,
      ACG_SRC_ASYN = 2'h3
   } acg_src_e;

   typedef enum logic [2:0] {
      ACG_IN_PIN  = 3'h0,
      ACG_IN_VRL  = 3'h1,
      ACG_IN_VRH  = 3'h2,
      ACG_IN_TEMP = 3'h3,
      ACG_IN_BG   = 3'h4,
      ACG_IN_RSV  = 3'h5,
      ACG_IN_OFF  = 3'h6
   } acg_in_e;

   typedef enum logic [2:0] {
      ACG_ST_IDLE  = 3'b001,
      ACG_ST_START = 3'b010,
      ACG_ST_BUSY  = 3'b100
   } acg_st_e;
endpackage : acg_pkg
`default_nettype wire

// [acg_per_cnt.sv]
// Purpose: Free-running periodic counter giving one pulse per overflow.
// Assumes: Tick inputs are one-cycle enables on the system clock.
// Notes:   Period is 2^(2*rate_select+1) input ticks.
`include "acg_cfg.svh"
`default_nettype none
module acg_per_cnt
(
   input  wire logic       i_ref_clk,
   input  wire logic       i_rst_n,
   input  wire logic       i_tick,
   input  wire logic [2:0] i_rate_sel,
   output logic            o_ovf
);
   logic [15:0] cnt;
   logic [15:0] top;

   // Period select picks the wrap value among eight powers of two
   assign top = 16'hFFFF >> (4'd15 - {1'b0, i_rate_sel} * 4'd2);

   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         cnt   <= 16'h0000;
         o_ovf <= 1'b0;
      end
      else
      begin
         o_ovf <= 1'b0;
         if (i_tick)
         begin
            if (cnt >= top)
            begin
               cnt   <= 16'h0000;
               o_ovf <= 1'b1;
            end
            else
               cnt <= cnt + 16'h0001;
         end
      end
   end
endmodule // acg_per_cnt
`default_nettype wire

// [acg_clk_div.sv]
// Purpose: Conversion clock enable from a selected source and divider.
// Assumes: Source edges arrive as one-cycle enables.
// Notes:   Divider ratio is 1, 2, 4 or 8.
`include "acg_cfg.svh"
`default_nettype none
module acg_clk_div
(
   input  wire logic       i_ref_clk,
   input  wire logic       i_rst_n,
   input  wire logic       i_src_en,
   input  wire logic [1:0] i_div,
   output logic            o_conv_en
);
   logic [2:0] cnt;
   logic [2:0] lim;

   assign lim = 3'((4'd1 << i_div) - 4'd1);

   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         cnt       <= 3'h0;
         o_conv_en <= 1'b0;
      end
      else
      begin
         // Compare with >= so a smaller ratio takes hold at the next edge
         o_conv_en <= i_src_en && (cnt >= lim);
         if (i_src_en)
            cnt <= (cnt >= lim) ? 3'h0 : cnt + 3'h1;
      end
   end
endmodule // acg_clk_div
`default_nettype wire

// [acg_core_model.sv]
// Purpose: Converter core stand-in: busy from start until done.
// Assumes: Conversion clock arrives as one-cycle enables.
// Notes:   Slow mode stretches a conversion so aborts can be forced.
`default_nettype none
module acg_core_model
(
   input  wire logic       i_ref_clk,
   input  wire logic       i_rst_b,
   input  wire logic       i_conv_start,
   input  wire logic       i_conv_clk_en,
   input  wire logic       i_slow,
   input  wire logic [2:0] i_input_kind,
   input  wire logic       i_bandgap_en,
   output logic            o_core_done,
   output logic            o_misuse
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [6:0] count;
   logic       busy;
   wire  [6:0] span = i_slow ? 7'h28 : 7'h04;

   always_ff @(posedge i_ref_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         busy        <= 1'b0;
         count       <= 7'h00;
         o_core_done <= 1'b0;
         o_misuse    <= 1'b0;
      end
      else
      begin
         o_core_done <= 1'b0;
         // Bandgap converted without its buffer gives garbage
         if (busy && i_input_kind == acg_pkg::ACG_IN_BG && !i_bandgap_en)
            o_misuse <= 1'b1;
         // A new start restarts the count, as an abort would
         if (i_conv_start)
         begin
            busy  <= 1'b1;
            count <= 7'h00;
         end
         else if (busy && i_conv_clk_en)
         begin
            count <= count + 7'h01;
            if (count == span - 7'h01)
            begin
               busy        <= 1'b0;
               o_core_done <= 1'b1;
            end
         end
      end
   end
endmodule // acg_core_model
`default_nettype wire

// [testbench.sv]
// Purpose: Self-checking bench for the converter glue block.
// Assumes: Zero-wait Wishbone slave; ticks made here on the bus clock.
// Notes:   Pulse counts allow one pulse of slack either way for pipeline phase.
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'h0;
   logic [31:0] wdat = 32'h0000_0000, rdat_o, rd;
   logic        ack, ext_tick = 1'b0, async_tick = 1'b0, done, misuse;
   logic        ext_mode = 1'b0, csb1 = 1'b0, wait_m = 1'b0, stop3 = 1'b0;
   logic        slow = 1'b0, start, abort, clk_en, off, bandgap_buffer_enable, low_voltage_detect_enable, low_voltage_detect_stop_enable;
   logic        st, ab;
   logic [4:0]  ch;
   logic [2:0]  kind;
   logic [15:0] pin_en;
   logic [7:0]  tick_cnt = 8'h00;
   int          mismatches = 0, total_checks = 0, cycles = 0;
   int          n_start = 0, n_clk = 0;
   logic [7:0]  ad_tab [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14,
                               8'h18, 8'h1C};
   logic [5:0]  rv_tab [8] = '{6'h1F, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00,
                               6'h01, 6'h00};
   logic [4:0]  ch_tab [10] = '{5'h00, 5'h04, 5'h0B, 5'h10, 5'h16, 5'h1A,
                                5'h1B, 5'h1C, 5'h1D, 5'h1E};
   logic [2:0]  kd_tab [10] = '{3'h0, 3'h1, 3'h0, 3'h1, 3'h5, 3'h3, 3'h4,
                                3'h5, 3'h2, 3'h1};
   // Row: src[7:6] div[5:4] ext mode, select bit 1, stop3, wait
   logic [7:0]  ck_tab [12] = '{8'h00, 8'h20, 8'h40, 8'h50, 8'h8C, 8'hAC,
                                8'h8D, 8'h8E, 8'h84, 8'h88, 8'hC0, 8'hD0};
   int          ck_exp [12] = '{64, 16, 32, 16, 16, 4, 16, 0, 0, 0, 8, 4};

   always #2.5 ref_clk = ~ref_clk;

   always @(posedge ref_clk)
   begin
      tick_cnt   <= tick_cnt + 8'h01;
      ext_tick   <= (tick_cnt[1:0] == 2'h3);
      async_tick <= (tick_cnt[2:0] == 3'h7);
      n_start    += int'(start);
      n_clk      += int'(clk_en);
      cycles     += 1;
      if (cycles == 10000)
      begin
         mismatches++;
         stop_test();
      end
   end

   acg_glue i_dut (.i_ref_clk(ref_clk), .i_rst_b(rst_b), .i_wb_cyc(cyc),
      .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
      .i_wb_dat(wdat), .o_wb_dat(rdat_o), .o_wb_ack(ack),
      .i_ext_ref_tick(ext_tick), .i_async_tick(async_tick),
      .i_ext_clk_mode(ext_mode), .i_clock_select_bit_1(csb1),
      .i_wait_mode(wait_m), .i_stop3_mode(stop3), .i_core_done(done),
      .o_channel_select(ch), .o_input_kind(kind), .o_pin_enable(pin_en),
      .o_conv_start(start), .o_conv_abort(abort), .o_conv_clk_en(clk_en),
      .o_module_off(off), .o_bandgap_buffer_enable(bandgap_buffer_enable),
      .o_lvd_enable(low_voltage_detect_enable), .o_lvd_stop_enable(low_voltage_detect_stop_enable));

   acg_core_model i_core (.i_ref_clk(ref_clk), .i_rst_b(rst_b),
      .i_conv_start(start), .i_conv_clk_en(clk_en), .i_slow(slow),
      .i_input_kind(kind), .i_bandgap_en(bandgap_buffer_enable), .o_core_done(done),
      .o_misuse(misuse));

   task automatic chk(input string name, input logic [31:0] seen, exp);
      total_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   function automatic logic [31:0] near(input int n, input int e);
      // No slack where nothing at all may happen
      return {31'h0, (n >= e - 1) && (n <= e + 1) && (e > 0 || n == 0)};
   endfunction

   // Classic single cycle; the answer's data and pulses are kept
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
      @(posedge ref_clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      sel  <= s;
      do
      begin
         @(posedge ref_clk);
         #1;
      end while (ack !== 1'b1);
      rd = rdat_o;
      st = start;
      ab = abort;
      @(posedge ref_clk);
      cyc <= 1'b0;
      stb <= 1'b0;
      #1;
   endtask

   task automatic count_starts(input int e);
      n_start = 0;
      repeat (256) @(posedge ref_clk);
      #1;
      chk("starts", near(n_start, e), 32'h1);
   endtask

   task automatic stop_test;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial
   begin
      repeat (8) @(posedge ref_clk);
      #1;
      chk("rst_out", {ch, kind, off, pin_en, start, abort, clk_en, bandgap_buffer_enable,
          low_voltage_detect_enable, low_voltage_detect_stop_enable}, {5'h1F, 3'h6, 1'b1, 22'h0});
      rst_b <= 1'b1;
      repeat (2) @(posedge ref_clk);
      for (int i = 0; i < 8; i++)
      begin
         wb(1'b0, ad_tab[i], 32'h0, 4'hF);
         chk("reg_rst", rd, {26'h0, rv_tab[i]});
      end
      wb(1'b1, 8'h18, 32'h0000_0000, 4'hF);
      wb(1'b0, 8'h18, 32'h0, 4'hF);
      chk("stat_ro", rd, 32'h0000_0001);
      wb(1'b1, 8'h08, 32'h0000_0005, 4'hF);
      wb(1'b1, 8'h0C, 32'h0000_000A, 4'hF);
      chk("pin_en", {16'h0, pin_en}, 32'h0000_0A05);
      // Buffer and detect enables go first, as software must
      wb(1'b1, 8'h10, 32'h0000_0007, 4'hF);
      wb(1'b1, 8'h10, 32'h0000_0000, 4'h0);
      chk("power", {29'h0, bandgap_buffer_enable, low_voltage_detect_enable, low_voltage_detect_stop_enable}, 32'h7);
      for (int i = 0; i < 10; i++)
      begin
         wb(1'b1, 8'h00, {27'h0, ch_tab[i]}, 4'hF);
         chk("chan", {st, off, ch, kind},
             {2'b10, ch_tab[i], kd_tab[i]});
      end
      wb(1'b1, 8'h00, 32'h0000_001F, 4'hF);
      chk("off", {st, off, kind}, {2'b01, 3'h6});
      slow = 1'b1;
      wb(1'b1, 8'h00, 32'h0000_0001, 4'hF);
      wb(1'b1, 8'h00, 32'h0000_0002, 4'hF);
      chk("abort", {st, ab}, 2'b11);
      while (done !== 1'b1) @(posedge ref_clk);
      wb(1'b1, 8'h00, 32'h0000_0003, 4'hF);
      chk("idle_start", {st, ab}, 2'b10);
      slow = 1'b0;
      for (int i = 0; i < 12; i++)
      begin
         @(posedge ref_clk);
         {ext_mode, csb1, stop3, wait_m} <= ck_tab[i][3:0];
         wb(1'b1, 8'h04, {28'h0, ck_tab[i][5:4], ck_tab[i][7:6]}, 4'hF);
         repeat (16) @(posedge ref_clk);
         #1;
         n_clk = 0;
         repeat (64) @(posedge ref_clk);
         #1;
         chk("clk_en", near(n_clk, ck_exp[i]),
             32'h1);
      end
      @(posedge ref_clk);
      {ext_mode, csb1, stop3, wait_m} <= 4'hC;
      wb(1'b1, 8'h04, 32'h0, 4'hF);
      wb(1'b0, 8'h18, 32'h0, 4'hF);
      chk("alt_live", {31'h0, rd[2]}, 32'h1);
      // External ticks every 4 cycles: wrap of 2 or 8 ticks
      wb(1'b1, 8'h00, 32'h0000_0021, 4'hF);
      count_starts(32);
      wb(1'b1, 8'h14, 32'h0000_0001, 4'hF);
      count_starts(8);
      wb(1'b1, 8'h00, 32'h0000_003F, 4'hF);
      count_starts(0);
      wb(1'b1, 8'h00, 32'h0000_0001, 4'hF);
      count_starts(0);
      chk("misuse", {31'h0, misuse}, 32'h0);
      stop_test();
   end
endmodule // testbench
`default_nettype wire
